// ===== src/ttb_pkg.sv
// constants and types shared by the timer time-base unit
package ttb_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;  // counter and reload width
  localparam int PSC_W = 16;  // prescaler width
  localparam int REP_W = 8;   // repeat counter width

  typedef logic [CNT_W-1:0] ttb_cnt_t;
  typedef logic [PSC_W-1:0] ttb_psc_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam ttb_cnt_t CNT_RST = 16'h0000;  // count value
  localparam ttb_cnt_t ARR_RST = 16'hffff;  // reload preload and active
  localparam ttb_psc_t PSC_RST = 16'h0000;  // prescale value and buffer
  localparam logic [REP_W-1:0] REP_RST = 8'h00;  // repeat value and counter

endpackage

// ===== src/ttb_tb_if.sv
// event wires between the counter core, prescaler and repeat counter
`timescale 1ns/1ps
`default_nettype none

interface ttb_tb_if;
  logic tick;      // prescaler output, one count step
  logic wrap;      // counter overflow or underflow
  logic force_up;  // forced update request, restarts counting
  logic upd;       // update event actually taken
  logic rep_zero;  // repeat counter has reached zero

  modport core (input tick, input rep_zero, output wrap, output force_up, output upd);
  modport psc  (input force_up, input upd, output tick);
  modport rep  (input wrap, input upd, output rep_zero);
endinterface

`default_nettype wire

// ===== src/ttb_prescaler.sv
// programmable clock prescaler with a buffered division ratio
`timescale 1ns/1ps
`default_nettype none

module ttb_prescaler
  import ttb_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic            run,
  input  wire ttb_pkg::ttb_psc_t psc_value,
  ttb_tb_if.psc                bus
);

  ttb_psc_t buf_q;  // ratio in force
  ttb_psc_t cnt_q;  // internal divider count

  // ----------------------------------------------------------------
  // ratio buffer
  // ----------------------------------------------------------------
  // ratio taken on update
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      buf_q <= PSC_RST;
    end else if (bus.upd) begin
      buf_q <= psc_value;
    end
  end

  // ----------------------------------------------------------------
  // divider counter
  // ----------------------------------------------------------------
  // divide by value plus one
  assign bus.tick = run && (cnt_q == buf_q);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= PSC_RST;
    end else if (bus.force_up || bus.tick) begin
      cnt_q <= '0;
    end else if (run) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  a_psc_tick_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus.tick |=> cnt_q == '0)
    else $error("prescaler did not restart after tick");

  a_psc_buf_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bus.upd |=> $stable(buf_q))
    else $error("prescaler ratio changed without update");

endmodule // ttb_prescaler

`default_nettype wire

// ===== src/ttb_repeat.sv
// repetition counter dividing overflows into update events
`timescale 1ns/1ps
`default_nettype none

module ttb_repeat
  import ttb_pkg::*;
#(
  parameter int REP_BITS = ttb_pkg::REP_W
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic [REP_BITS-1:0] rep_value,
  ttb_tb_if.rep                    bus
);

  logic [REP_BITS-1:0] rep_q;  // remaining wraps before update

  assign bus.rep_zero = (rep_q == '0);

  // ----------------------------------------------------------------
  // repeat down counter
  // ----------------------------------------------------------------
  // step down on each wrap until zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rep_q <= REP_BITS'(REP_RST);
    end else if (bus.upd) begin
      rep_q <= rep_value;
    end else if (bus.wrap && !bus.rep_zero) begin
      rep_q <= rep_q - 1'b1;
    end
  end

  a_rep_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus.wrap && !bus.rep_zero && !bus.upd |=> rep_q == $past(rep_q) - 1'b1)
    else $error("repeat counter missed a step");

  a_rep_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus.upd |=> rep_q == $past(rep_value))
    else $error("repeat counter not reloaded on update");

endmodule // ttb_repeat

`default_nettype wire

// ===== src/ttb_time_base.sv
// time-base unit: counter, reload, prescaler and update logic
`timescale 1ns/1ps
`default_nettype none

module ttb_time_base
  import ttb_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      counter_run_bit,
  input  wire logic                      count_down,
  input  wire logic                      reload_preload_enable,
  input  wire logic                      suppress_update_bit,
  input  wire logic                      update_source_select,
  input  wire logic                      force_update_bit,
  input  wire logic                      flag_clear,
  input  wire logic                      count_wr,
  input  wire ttb_pkg::ttb_cnt_t         count_wdata,
  input  wire logic                      reload_wr,
  input  wire ttb_pkg::ttb_cnt_t         reload_wdata,
  input  wire logic                      prescale_wr,
  input  wire ttb_pkg::ttb_psc_t         prescale_wdata,
  input  wire logic                      repeat_wr,
  input  wire logic [ttb_pkg::REP_W-1:0] repeat_wdata,
  output logic      [ttb_pkg::CNT_W-1:0] count_value,
  output logic      [ttb_pkg::CNT_W-1:0] reload_value,
  output logic      [ttb_pkg::CNT_W-1:0] reload_active,
  output logic      [ttb_pkg::PSC_W-1:0] prescale_value,
  output logic      [ttb_pkg::REP_W-1:0] repeat_value,
  output logic                           update_flag,
  output logic                           update_pulse,
  output logic                           wrap_pulse
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ttb_tb_if tb ();

  ttb_cnt_t         cnt_q;         // count value
  ttb_cnt_t         cnt_d;
  ttb_cnt_t         arr_pre_q;     // reload preload, software view
  ttb_cnt_t         arr_pre_d;
  ttb_cnt_t         arr_act_q;     // reload in force
  ttb_cnt_t         arr_act_d;
  ttb_psc_t         psc_pre_q;     // prescale value, software view
  logic [REP_W-1:0] rep_val_q;     // repeat value, software view
  logic             flag_q;        // update flag
  logic             upd_pulse_q;   // registered update event
  logic             wrap_pulse_q;  // registered overflow/underflow
  logic             wrap;          // counter wraps this cycle
  logic             upd_wrap;      // update caused by a wrap
  logic             upd_force;     // update caused by force bit

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  // divider feeding the count tick
  ttb_prescaler u_psc (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .run       (counter_run_bit),
    .psc_value (psc_pre_q),
    .bus       (tb.psc)
  );

  // repetition counter gating wrap updates
  ttb_repeat #(
    .REP_BITS (REP_W)
  ) u_rep (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .rep_value (rep_val_q),
    .bus       (tb.rep)
  );

  // ----------------------------------------------------------------
  // update event generation
  // ----------------------------------------------------------------
  // wrap updates only at repeat zero
  assign upd_wrap  = wrap && tb.rep_zero && !suppress_update_bit;
  assign upd_force = force_update_bit && !suppress_update_bit;

  assign tb.force_up = force_update_bit;
  assign tb.wrap     = wrap;
  assign tb.upd      = upd_wrap || upd_force;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // reload writes go to preload
  assign arr_pre_d = reload_wr ? reload_wdata : arr_pre_q;

  // preload of the reload value
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arr_pre_q <= ARR_RST;
    end else begin
      arr_pre_q <= arr_pre_d;
    end
  end

  always_comb begin
    if (!reload_preload_enable || tb.upd) begin
      arr_act_d = arr_pre_d;
    end else begin
      arr_act_d = arr_act_q;
    end
  end

  // active reload register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arr_act_q <= ARR_RST;
    end else begin
      arr_act_q <= arr_act_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      psc_pre_q <= PSC_RST;
    end else if (prescale_wr) begin
      psc_pre_q <= prescale_wdata;
    end
  end

  // repeat value holding register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rep_val_q <= REP_RST;
    end else if (repeat_wr) begin
      rep_val_q <= repeat_wdata;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // overflow at reload value counting up, underflow at zero counting down
  always_comb begin
    wrap = 1'b0;
    if (!force_update_bit && !count_wr && tb.tick) begin
      if (count_down) begin
        wrap = (cnt_q == '0);
      end else begin
        wrap = (cnt_q == arr_act_q);
      end
    end
  end

  // next count: force, then write, then tick
  always_comb begin
    cnt_d = cnt_q;
    if (force_update_bit) begin
      cnt_d = count_down ? arr_act_d : '0;
    end else if (count_wr) begin
      cnt_d = count_wdata;
    end else if (tb.tick) begin
      if (count_down) begin
        cnt_d = wrap ? arr_act_d : cnt_q - 1'b1;
      end else begin
        cnt_d = wrap ? '0 : cnt_q + 1'b1;
      end
    end
  end

  // count register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // update flag and event pulses
  // ----------------------------------------------------------------
  // forced update flag hidden by select
  // update sets flag, set beats clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (upd_wrap || (upd_force && !update_source_select)) begin
      flag_q <= 1'b1;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  // event pulses, one cycle late
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      upd_pulse_q  <= 1'b0;
      wrap_pulse_q <= 1'b0;
    end else begin
      upd_pulse_q  <= tb.upd;
      wrap_pulse_q <= wrap;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign count_value    = cnt_q;
  assign reload_value   = arr_pre_q;
  assign reload_active  = arr_act_q;
  assign prescale_value = psc_pre_q;
  assign repeat_value   = rep_val_q;
  assign update_flag    = flag_q;
  assign update_pulse   = upd_pulse_q;
  assign wrap_pulse     = wrap_pulse_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // idle without run
  a_run_gates_count: assert property (@(posedge core_clk) disable iff (sys_rst)
    !counter_run_bit && !force_update_bit && !count_wr |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  a_up_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    tb.tick && !count_down && !wrap && !force_update_bit && !count_wr
    |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("up count did not step by one");

  a_up_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    tb.tick && !count_down && cnt_q == arr_act_q && !force_update_bit && !count_wr
    |=> cnt_q == '0 && wrap_pulse)
    else $error("overflow did not wrap to zero");

  a_down_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    tb.tick && count_down && cnt_q == '0 && !force_update_bit && !count_wr
    |=> cnt_q == arr_act_q && wrap_pulse)
    else $error("underflow did not reload the count");

  a_force_up: assert property (@(posedge core_clk) disable iff (sys_rst)
    force_update_bit && !count_down |=> cnt_q == '0)
    else $error("forced update did not clear the count");

  a_force_down: assert property (@(posedge core_clk) disable iff (sys_rst)
    force_update_bit && count_down |=> cnt_q == arr_act_q)
    else $error("forced update did not load the reload value");

  a_force_update: assert property (@(posedge core_clk) disable iff (sys_rst)
    force_update_bit && !suppress_update_bit |=> update_pulse)
    else $error("forced update produced no event");

  a_suppress_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    suppress_update_bit && reload_preload_enable |=> !update_pulse && $stable(arr_act_q))
    else $error("update happened while suppressed");

  a_direct_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reload_preload_enable && reload_wr |=> arr_act_q == $past(reload_wdata))
    else $error("reload not copied at once");

  a_source_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    force_update_bit && update_source_select && !flag_clear
    |=> update_flag == $past(update_flag))
    else $error("flag changed on hidden forced update");

  a_wrap_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    upd_wrap |=> update_flag && update_pulse)
    else $error("wrap update did not set the flag");

  a_rep_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrap && !tb.rep_zero && !force_update_bit |=> !update_pulse)
    else $error("update before repeat count expired");

  a_down_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    tb.tick && count_down && !wrap && !force_update_bit && !count_wr
    |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("down count did not step by one");

  a_suppress_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    suppress_update_bit && !update_flag |=> !update_flag)
    else $error("flag set while updates suppressed");

  a_update_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
    tb.upd |=> arr_act_q == $past(arr_pre_d))
    else $error("update did not copy the reload preload");

  a_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    flag_clear && !upd_wrap && !(upd_force && !update_source_select) |=> !update_flag)
    else $error("flag clear had no effect");

  a_rep_expire: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrap && tb.rep_zero && !suppress_update_bit |=> update_pulse)
    else $error("no update when repeat count expired");

  a_preload_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    reload_preload_enable && !tb.upd |=> $stable(arr_act_q))
    else $error("active reload changed without update");

endmodule // ttb_time_base

`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the timer time-base unit with a cycle reference model
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ttb_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int CYC_MAX = 20000;  // run needs about 6100 cycles

  logic                     core_clk;
  logic                     sys_rst;
  logic                     counter_run_bit;
  logic                     count_down;
  logic                     reload_preload_enable;
  logic                     suppress_update_bit;
  logic                     update_source_select;
  logic                     force_update_bit;
  logic                     flag_clear;
  logic                     count_wr;
  ttb_cnt_t                 count_wdata;
  logic                     reload_wr;
  ttb_cnt_t                 reload_wdata;
  logic                     prescale_wr;
  ttb_psc_t                 prescale_wdata;
  logic                     repeat_wr;
  logic [REP_W-1:0]         repeat_wdata;
  logic [CNT_W-1:0]         count_value;
  logic [CNT_W-1:0]         reload_value;
  logic [CNT_W-1:0]         reload_active;
  logic [PSC_W-1:0]         prescale_value;
  logic [REP_W-1:0]         repeat_value;
  logic                     update_flag;
  logic                     update_pulse;
  logic                     wrap_pulse;
  int                       num_errors;
  int                       tests_run;
  int                       cyc;
  int                       b;
  logic                     started;
  logic                     sup_blk;
  logic [31:0]              r;
  logic [31:0]              r2;
  ttb_cnt_t                 m_cnt, m_pre, m_act;
  ttb_psc_t                 m_psc, m_pbuf, m_pcnt;
  logic [REP_W-1:0]         m_rv, m_rc;
  logic                     m_flag, m_up, m_wp;

  ttb_time_base i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .counter_run_bit(counter_run_bit),
    .count_down(count_down), .reload_preload_enable(reload_preload_enable),
    .suppress_update_bit(suppress_update_bit), .update_source_select(update_source_select),
    .force_update_bit(force_update_bit), .flag_clear(flag_clear), .count_wr(count_wr),
    .count_wdata(count_wdata), .reload_wr(reload_wr), .reload_wdata(reload_wdata),
    .prescale_wr(prescale_wr), .prescale_wdata(prescale_wdata), .repeat_wr(repeat_wr),
    .repeat_wdata(repeat_wdata), .count_value(count_value), .reload_value(reload_value),
    .reload_active(reload_active), .prescale_value(prescale_value),
    .repeat_value(repeat_value), .update_flag(update_flag), .update_pulse(update_pulse),
    .wrap_pulse(wrap_pulse)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // expected next count from the counting rules
  function automatic ttb_cnt_t exp_count(input logic frc, cw, dn, e, w,
                                         input ttb_cnt_t c, wd, act);
    if (frc) return dn ? act : 16'h0000;
    if (cw) return wd;
    if (!e) return c;
    if (dn) return w ? act : c - 16'h0001;
    return w ? 16'h0000 : c + 16'h0001;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d of %0d compares", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one strobe for one cycle: 0 force 1 clear 2 count 3 reload 4 prescale 5 repeat
  task automatic strobe(input int k, input logic [15:0] d);
    @(posedge core_clk);
    force_update_bit <= (k == 0);
    flag_clear       <= (k == 1);
    count_wr         <= (k == 2);
    reload_wr        <= (k == 3);
    prescale_wr      <= (k == 4);
    repeat_wr        <= (k == 5);
    count_wdata      <= d;
    reload_wdata     <= d;
    prescale_wdata   <= d;
    repeat_wdata     <= d[7:0];
    @(posedge core_clk);
    {force_update_bit, flag_clear, count_wr, reload_wr, prescale_wr, repeat_wr} <= 6'h00;
  endtask

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // reference model, stepped on each rising edge from sampled inputs
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin : ref_model
    logic tk, et, wr, up;
    started = 1'b1;
    if (sys_rst) begin
      {m_cnt, m_psc, m_pbuf, m_pcnt} = '0;
      {m_pre, m_act} = {ARR_RST, ARR_RST};
      {m_rv, m_rc, m_flag, m_up, m_wp} = '0;
    end else begin
      tk = counter_run_bit && (m_pcnt == m_pbuf);
      et = tk && !count_wr && !force_update_bit;
      wr = et && (count_down ? (m_cnt == 16'h0000) : (m_cnt == m_act));
      up = !suppress_update_bit && (force_update_bit || (wr && m_rc == 8'h00));
      m_wp = wr;
      m_up = up;
      if (up && !(force_update_bit && update_source_select)) m_flag = 1'b1;
      else if (flag_clear) m_flag = 1'b0;
      // reload preload transfer, same-cycle write included
      if (reload_wr) m_pre = reload_wdata;
      if (up || !reload_preload_enable) m_act = m_pre;
      m_cnt = exp_count(force_update_bit, count_wr, count_down, et, wr,
                        m_cnt, count_wdata, m_act);
      m_pcnt = (force_update_bit || tk) ? 16'h0000 :
               (counter_run_bit ? m_pcnt + 16'h0001 : m_pcnt);
      if (up) m_pbuf = m_psc;
      if (prescale_wr) m_psc = prescale_wdata;
      m_rc = up ? m_rv : ((wr && m_rc != 8'h00) ? m_rc - 8'h01 : m_rc);
      if (repeat_wr) m_rv = repeat_wdata;
    end
  end

  // compare every output with the model away from the clock edge
  always @(negedge core_clk) begin
    if (started) begin
      check(32'(count_value), 32'(m_cnt));
      check(32'(count_value), 32'(m_cnt));
      check(32'(reload_value), 32'(m_pre));
      check(32'(reload_active), 32'(m_act));
      check(32'(prescale_value), 32'(m_psc));
      check(32'(repeat_value), 32'(m_rv));
      check(32'(update_flag), 32'(m_flag));
      check(32'(update_pulse), 32'(m_up));
      check(32'(wrap_pulse), 32'(m_wp));
    end
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    {num_errors, tests_run, cyc} = '0;
    started = 1'b0;
    r = 32'd99160;
    sys_rst = 1'b1;
    {counter_run_bit, count_down, reload_preload_enable} = 3'h0;
    {suppress_update_bit, update_source_select, force_update_bit, flag_clear} = 4'h0;
    {count_wr, reload_wr, prescale_wr, repeat_wr} = 4'h0;
    {count_wdata, reload_wdata, prescale_wdata, repeat_wdata} = '0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    // short up period, flag after three ticks
    strobe(3, 16'h0002);
    counter_run_bit <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check(32'(update_flag), 32'h1);
    check(32'(count_value), 32'h0);
    // ratio change waits for the next update, then forced updates
    strobe(4, 16'h0001);
    repeat (8) @(posedge core_clk);
    strobe(1, 16'h0000);
    strobe(0, 16'h0000);
    update_source_select <= 1'b1;
    strobe(1, 16'h0000);
    strobe(0, 16'h0000);
    suppress_update_bit <= 1'b1;
    strobe(0, 16'h0000);
    repeat (12) @(posedge core_clk);
    suppress_update_bit <= 1'b0;
    // down with preload and repeat of two
    {count_down, reload_preload_enable} <= 2'b11;
    strobe(5, 16'h0002);
    strobe(3, 16'h0005);
    repeat (40) @(posedge core_clk);
    // random blocks across twelve of the sixteen mode combinations
    for (b = 0; b < 12; b++) begin
      count_down            <= b[0];
      reload_preload_enable <= b[1];
      update_source_select  <= b[2];
      sup_blk = b[3];
      repeat (500) begin
        @(posedge core_clk);
        r = xs(r);
        r2 = xs(r);
        counter_run_bit     <= (r[31:28] != 4'h0);
        suppress_update_bit <= sup_blk && r[27];
        force_update_bit    <= (r[26:22] == 5'h00);
        flag_clear          <= (r[21:19] == 3'h0);
        count_wr            <= (r[18:14] == 5'h00);
        reload_wr           <= (r[13:10] == 4'h0);
        prescale_wr         <= (r[9:6] == 4'h0);
        repeat_wr           <= (r[5:2] == 4'h0);
        count_wdata         <= {11'h000, r2[4:0]};
        reload_wdata        <= {11'h000, r2[9:5]};
        prescale_wdata      <= {14'h0000, r2[11:10]};
        repeat_wdata        <= {6'h00, r2[13:12]};
        r = r2;
      end
    end
    // second reset in mid-run
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    complete_run();
  end

endmodule // tb

`default_nettype wire
